/* File: fqc_ctrl.sv */
// Host-side controller driving the flash command and read cycles
`timescale 1ns/1ns
`default_nettype none
module fqc_ctrl
  import fqc_pkg::*;
(
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              sys_rst,
  // Software port
  input  wire logic [3:0]        sw_addr,
  input  wire logic [31:0]       sw_wdata,
  input  wire logic              sw_wr,
  input  wire logic              sw_rd,
  output var  logic [31:0]       sw_rdata,
  // Flash pins
  output var  logic              flash_ce_n,
  output var  logic              flash_we_n,
  output var  logic              flash_oe_n,
  output var  logic              flash_byte_n,
  output var  logic [ADDR_W-1:0] flash_addr,
  output var  logic [DATA_W-1:0] flash_dq_o,
  output var  logic              flash_dq_oe,
  input  wire logic [DATA_W-1:0] flash_dq_i,
  input  wire logic              timing_limit_flag
);

  // ---------------------------------------------------------------
  // Macro sequences: list of cycles per software opcode
  // ---------------------------------------------------------------
  // Longest sequence is three writes (autoselect); a read is appended
  // by software as a separate OP_READ.
  localparam int SEQ_MAX = 3;

  fqc_state_e        state, next_state;
  fqc_pins_s         pins, next_pins;
  logic [7:0]        cnt, next_cnt;
  fqc_cycle_s        seq [SEQ_MAX];
  fqc_cycle_s        next_seq [SEQ_MAX];
  logic [1:0]        seq_len, next_seq_len;
  logic [1:0]        seq_idx, next_seq_idx;
  logic              is_read, next_is_read;
  logic [ADDR_W-1:0] reg_addr, next_reg_addr;
  logic [DATA_W-1:0] reg_wdata, next_reg_wdata;
  logic [DATA_W-1:0] rdata, next_rdata;
  logic              byte_mode, next_byte_mode;
  logic              byte_n, next_byte_n;
  logic              top_boot, next_top_boot;
  logic [7:0]        uni_cnt, next_uni_cnt;
  fqc_mode_e         mode, next_mode;
  logic              done, next_done;
  logic              qry_err, next_qry_err;
  logic              limit_seen, next_limit_seen;
  logic [31:0]       sw_q, next_sw_q;

  // Word-mode address scaled into the bus address
  function automatic logic [ADDR_W-1:0] bus_adr(input logic [ADDR_W-1:0] a,
                                                input logic bm);
    return bm ? {a[ADDR_W-2:0], 1'b0} : a;
  endfunction : bus_adr

  function automatic fqc_cycle_s cyc(input logic [ADDR_W-1:0] a,
                                     input logic [15:0] d,
                                     input logic bm);
    fqc_cycle_s c;
    c.addr = bus_adr(a, bm);
    c.data = d;
    return c;
  endfunction : cyc

  // Sequencer busy; command and configuration writes are dropped unless idle
  wire busy = (state != ST_IDLE);

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    next_state      = state;
    next_pins       = pins;
    next_cnt        = cnt;
    next_seq        = seq;
    next_seq_len    = seq_len;
    next_seq_idx    = seq_idx;
    next_is_read    = is_read;
    next_reg_addr   = reg_addr;
    next_reg_wdata  = reg_wdata;
    next_rdata      = rdata;
    next_byte_mode  = byte_mode;
    next_top_boot   = top_boot;
    next_uni_cnt    = uni_cnt;
    next_mode       = mode;
    next_done       = done;
    next_qry_err    = qry_err;
    next_limit_seen = limit_seen | timing_limit_flag;
    next_sw_q       = 32'h0000_0000;

    if (sw_rd) begin
      case (sw_addr)
        REG_ADDR:   next_sw_q = {11'h000, reg_addr};
        REG_WDATA:  next_sw_q = {16'h0000, reg_wdata};
        REG_STATUS: next_sw_q = {26'h000_0000, limit_seen, qry_err,
                                 mode, done, busy};
        REG_RDATA:  next_sw_q = {16'h0000, rdata};
        REG_CFG:    next_sw_q = {22'h00_0000, uni_cnt, top_boot,
                                 byte_mode};
        default:    next_sw_q = 32'h0000_0000;
      endcase
    end

    if (sw_wr) begin
      case (sw_addr)
        REG_ADDR:  next_reg_addr  = sw_wdata[ADDR_W-1:0];
        REG_WDATA: next_reg_wdata = sw_wdata[DATA_W-1:0];
        REG_STATUS: begin
          // Clear-on-write; a flag rising this cycle still wins
          if (sw_wdata[4]) next_qry_err = 1'b0;
          if (sw_wdata[5]) next_limit_seen = timing_limit_flag;
          if (sw_wdata[1]) next_done = 1'b0;
        end
        REG_CFG: if (!busy) begin
          next_byte_mode = sw_wdata[0];
          next_top_boot  = sw_wdata[1];
          next_uni_cnt   = sw_wdata[9:2];
        end
        REG_CMD: if (!busy) begin
          next_seq_idx = 2'd0;
          next_is_read = 1'b0;
          next_seq_len = 2'd1;
          next_done    = 1'b0;
          next_seq[0]  = cyc(reg_addr, reg_wdata, byte_mode);
          case (sw_wdata[2:0])
            OP_WRITE: next_state = ST_SETUP;
            OP_READ: begin
              next_is_read = 1'b1;
              next_state   = ST_SETUP;
            end
            OP_RESET: begin
              // Address is a don't-care for reset
              next_seq[0] = cyc(reg_addr, CMD_RESET, byte_mode);
              next_mode   = MD_READ;
              next_state  = ST_SETUP;
            end
            OP_AUTOSEL: if (mode == MD_READ) begin
              next_seq[0]  = cyc(ADR_UNLK1, CMD_UNLK1, byte_mode);
              next_seq[1]  = cyc(ADR_UNLK2, CMD_UNLK2, byte_mode);
              // Bank bits ride on the third cycle's address
              next_seq[2]  = cyc({reg_addr[ADDR_W-1:12], ADR_UNLK1[11:0]},
                                 CMD_AUTOSEL, byte_mode);
              next_seq_len = 2'd3;
              next_mode    = MD_AUTOSEL;
              next_state   = ST_SETUP;
            end
            OP_QUERY: begin
              next_seq[0] = cyc(ADR_QUERY, CMD_QUERY, byte_mode);
              next_mode   = MD_QUERY;
              next_state  = ST_SETUP;
            end
            default: next_state = ST_IDLE;
          endcase
        end
        default: next_state = next_state;
      endcase
    end

    case (state)
      ST_IDLE: begin
        next_pins.ce_n  = 1'b1;
        next_pins.we_n  = 1'b1;
        next_pins.oe_n  = 1'b1;
        next_pins.dq_oe = 1'b0;
      end
      ST_SETUP: begin
        // Address settles while both strobes are high
        next_pins.addr   = seq[seq_idx].addr;
        next_pins.dq_out = seq[seq_idx].data;
        next_pins.ce_n   = 1'b0;
        next_cnt         = 8'(SETUP_CYC - 1);
        next_state       = is_read ? ST_RDLOW : ST_WRLOW;
      end
      ST_WRLOW: begin
        // CE falls first, WE after it: address latched on WE fall
        next_pins.we_n  = 1'b0;
        next_pins.dq_oe = 1'b1;
        if (!pins.we_n) begin
          if (cnt == 8'd0) begin
            next_pins.we_n = 1'b1;
            next_cnt       = 8'(WPH_CYC - 1);
            next_state     = ST_WRHI;
          end else begin
            next_cnt = cnt - 8'd1;
          end
        end else begin
          next_cnt = 8'(WP_CYC - 1);
        end
      end
      ST_WRHI: begin
        // Data held through the WE rise, then released
        next_pins.ce_n = 1'b1;
        if (cnt == 8'd0) begin
          next_pins.dq_oe = 1'b0;
          if (seq_idx + 2'd1 == seq_len) begin
            next_state = ST_IDLE;
            next_done  = 1'b1;
          end else begin
            next_seq_idx = seq_idx + 2'd1;
            next_state   = ST_SETUP;
          end
        end else begin
          next_cnt = cnt - 8'd1;
        end
      end
      ST_RDLOW: begin
        // Sampled only once the full access time has run out
        next_pins.oe_n = 1'b0;
        if (!pins.oe_n && cnt == 8'd0) begin
          next_rdata = flash_dq_i;
          next_state = ST_RDHI;
          // Check extended table words while in query mode
          if (mode == MD_QUERY && reg_addr[7:4] == QRY_BASE[7:4] &&
              flash_dq_i != qry_expect(reg_addr[3:0], top_boot, uni_cnt))
            next_qry_err = 1'b1;
        end else if (pins.oe_n) begin
          next_cnt = 8'(ACCESS_CYC - 1);
        end else begin
          next_cnt = cnt - 8'd1;
        end
      end
      ST_RDHI: begin
        next_pins.oe_n = 1'b1;
        next_pins.ce_n = 1'b1;
        next_done      = 1'b1;
        next_state     = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
    // Byte pin tracks the mode register so it stays a flop output
    next_byte_n = ~next_byte_mode;
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state      <= ST_IDLE;
      pins       <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, dq_oe: 1'b0,
                      addr: '0, dq_out: '0};
      cnt        <= 8'h00;
      seq        <= '{default: '0};
      seq_len    <= 2'd0;
      seq_idx    <= 2'd0;
      is_read    <= 1'b0;
      reg_addr   <= '0;
      reg_wdata  <= '0;
      rdata      <= '0;
      byte_mode  <= 1'b0;
      byte_n     <= 1'b1;
      top_boot   <= 1'b0;
      uni_cnt    <= QRY_UNIFORM[7:0];
      mode       <= MD_READ;
      done       <= 1'b0;
      qry_err    <= 1'b0;
      limit_seen <= 1'b0;
      sw_q       <= 32'h0000_0000;
    end else begin
      state      <= next_state;
      pins       <= next_pins;
      cnt        <= next_cnt;
      seq        <= next_seq;
      seq_len    <= next_seq_len;
      seq_idx    <= next_seq_idx;
      is_read    <= next_is_read;
      reg_addr   <= next_reg_addr;
      reg_wdata  <= next_reg_wdata;
      rdata      <= next_rdata;
      byte_mode  <= next_byte_mode;
      byte_n     <= next_byte_n;
      top_boot   <= next_top_boot;
      uni_cnt    <= next_uni_cnt;
      mode       <= next_mode;
      done       <= next_done;
      qry_err    <= next_qry_err;
      limit_seen <= next_limit_seen;
      sw_q       <= next_sw_q;
    end
  end

  // ---------------------------------------------------------------
  // Pin outputs, each straight from a register
  // ---------------------------------------------------------------
  always_comb begin
    sw_rdata     = sw_q;
    flash_ce_n   = pins.ce_n;
    flash_we_n   = pins.we_n;
    flash_oe_n   = pins.oe_n;
    flash_byte_n = byte_n;
    flash_addr   = pins.addr;
    flash_dq_o   = pins.dq_out;
    flash_dq_oe  = pins.dq_oe;
  end

endmodule : fqc_ctrl
`default_nettype wire

/* File: fqc_pkg.sv */
// Package: constants, types and command codes for the flash query controller
// Behaviour
// - Address taken at the later falling strobe, data at the earlier rise.
// - Host sends reset after a timing-limit flag or to leave autoselect.
// - Autoselect is two unlock cycles then bank address with command.
// - Autoselect only to a reading bank, never while the other bank is busy.
package fqc_pkg;

  localparam int           ADDR_W      = 21;
  localparam int           DATA_W      = 16;
  // Software port offsets
  localparam logic [3:0]   REG_CMD     = 4'h0;
  localparam logic [3:0]   REG_ADDR    = 4'h1;
  localparam logic [3:0]   REG_WDATA   = 4'h2;
  localparam logic [3:0]   REG_STATUS  = 4'h3;
  localparam logic [3:0]   REG_RDATA   = 4'h4;
  localparam logic [3:0]   REG_CFG     = 4'h5;
  // Command opcodes written to REG_CMD
  localparam logic [2:0]   OP_WRITE    = 3'h1;
  localparam logic [2:0]   OP_READ     = 3'h2;
  localparam logic [2:0]   OP_RESET    = 3'h3;
  localparam logic [2:0]   OP_AUTOSEL  = 3'h4;
  localparam logic [2:0]   OP_QUERY    = 3'h5;
  // Flash command data and unlock addresses (word mode)
  localparam logic [15:0]  CMD_RESET   = 16'h00F0;
  localparam logic [15:0]  CMD_UNLK1   = 16'h00AA;
  localparam logic [15:0]  CMD_UNLK2   = 16'h0055;
  localparam logic [15:0]  CMD_AUTOSEL = 16'h0090;
  localparam logic [15:0]  CMD_QUERY   = 16'h0098;
  localparam logic [20:0]  ADR_UNLK1   = 21'h00_0555;
  localparam logic [20:0]  ADR_UNLK2   = 21'h00_02AA;
  localparam logic [20:0]  ADR_QUERY   = 21'h00_0055;
  // Autoselect offsets in word mode; byte mode doubles them
  localparam logic [7:0]   AS_MAKER    = 8'h00;
  localparam logic [7:0]   AS_DEVICE   = 8'h01;
  localparam logic [7:0]   AS_PROTECT  = 8'h02;
  // Extended query table, word addresses
  localparam logic [7:0]   QRY_BASE    = 8'h40;
  localparam int           QRY_LEN     = 16;
  localparam logic [15:0]  QRY_UNIFORM = 16'h0000;
  // Bus timing in ns and derived cycle counts at 4 ns
  localparam int           CLK_NS      = 4;
  localparam int           T_SETUP_NS  = 0;
  localparam int           T_WP_NS     = 35;
  localparam int           T_WPH_NS    = 30;
  localparam int           T_ACCESS_NS = 85;
  localparam int           SETUP_CYC   = (T_SETUP_NS + CLK_NS - 1) / CLK_NS
                                         + 1;
  localparam int           WP_CYC      = (T_WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int           WPH_CYC     = (T_WPH_NS + CLK_NS - 1) / CLK_NS;
  localparam int           ACCESS_CYC  = (T_ACCESS_NS + CLK_NS - 1) / CLK_NS
                                         + 1;

  typedef struct packed {
    logic              ce_n;
    logic              we_n;
    logic              oe_n;
    logic              dq_oe;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq_out;
  } fqc_pins_s;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_SETUP = 3'b001,
    ST_WRLOW = 3'b010,
    ST_WRHI  = 3'b011,
    ST_RDLOW = 3'b100,
    ST_RDHI  = 3'b101
  } fqc_state_e;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } fqc_cycle_s;

  typedef enum logic [1:0] {
    MD_READ    = 2'b00,
    MD_AUTOSEL = 2'b01,
    MD_QUERY   = 2'b10
  } fqc_mode_e;

  // Expected extended query word at table index 0..15
  function automatic logic [15:0] qry_expect(input logic [3:0] idx,
                                             input logic       top_boot,
                                             input logic [7:0] uni_cnt);
    logic [15:0] v;
    v = 16'h0000;
    case (idx)
      4'h0:    v = 16'h0050;
      4'h1:    v = 16'h0052;
      4'h2:    v = 16'h0049;
      4'h3:    v = 16'h0031;
      4'h4:    v = 16'h0031;
      4'h6:    v = 16'h0002;
      4'h7:    v = 16'h0001;
      4'h8:    v = 16'h0001;
      4'h9:    v = 16'h0004;
      4'hA:    v = {8'h00, uni_cnt};
      4'hD:    v = 16'h0085;
      4'hE:    v = 16'h0095;
      4'hF:    v = top_boot ? 16'h0003 : 16'h0002;
      default: v = 16'h0000;
    endcase
    return v;
  endfunction : qry_expect

endpackage : fqc_pkg

/* File: fqc_ctrl_sva.sv */
// Checker: flash strobe, hold and access timing of the controller
`timescale 1ns/1ns
`default_nettype none
module fqc_ctrl_sva
  import fqc_pkg::*;
(
  // Clock and reset
  input wire logic              mclk,
  input wire logic              sys_rst,
  // Flash pins
  input wire logic              flash_ce_n,
  input wire logic              flash_we_n,
  input wire logic              flash_oe_n,
  input wire logic              flash_byte_n,
  input wire logic [ADDR_W-1:0] flash_addr,
  input wire logic [DATA_W-1:0] flash_dq_o,
  input wire logic              flash_dq_oe
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  rst_idle_a: assert property (disable iff (1'b0) sys_rst |=>
    flash_ce_n && flash_we_n && flash_oe_n && !flash_dq_oe)
    else $error("flash pins not idle after reset");
  we_in_ce_a: assert property (!flash_we_n |-> !flash_ce_n)
    else $error("write strobe outside select");
  wr_hold_a: assert property (!flash_we_n |-> flash_dq_oe &&
    $stable(flash_addr) && $stable(flash_dq_o))
    else $error("address or data moved under write strobe");
  we_width_a: assert property ($fell(flash_we_n) |->
    ##8 !flash_we_n ##1 flash_we_n) else $error("write strobe width");
  data_hold_a: assert property ($rose(flash_we_n) |->
    !flash_ce_n && flash_dq_oe ##1 (flash_ce_n && flash_dq_oe) [*7])
    else $error("data released too early");
  no_clash_a: assert property (!flash_oe_n |->
    flash_we_n && !flash_dq_oe) else $error("read and write overlap");
  rd_access_a: assert property ($fell(flash_oe_n) |->
    !$past(flash_ce_n) ##22 !flash_oe_n && !flash_ce_n)
    else $error("read access cut short");
  byte_keep_a: assert property (!flash_ce_n |->
    $stable(flash_byte_n)) else $error("byte mode changed in cycle");
endmodule : fqc_ctrl_sva
bind fqc_ctrl fqc_ctrl_sva fqc_ctrl_sva_i (.mclk, .sys_rst, .flash_ce_n,
  .flash_we_n, .flash_oe_n, .flash_byte_n, .flash_addr, .flash_dq_o,
  .flash_dq_oe);
`default_nettype wire

/* File: fqc_flash_mdl.sv */
// Behavioural flash: command decoder, query table, autoselect codes
`timescale 1ns/1ns
`default_nettype none
module fqc_flash_mdl
  import fqc_pkg::*;
#(
  parameter logic [15:0] MAKER  = 16'h00C3, // Arbitrary value
  parameter logic [15:0] DEVICE = 16'h5A3C, // Arbitrary value
  parameter logic [7:0]  UNI    = 8'h1E,
  parameter logic        TOP    = 1'b0
)
(
  // Host side pins
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic              ce_n,
  input  wire logic              we_n,
  input  wire logic              oe_n,
  input  wire logic              byte_n,
  input  wire logic [DATA_W-1:0] dq_in,
  output var  logic [DATA_W-1:0] dq_out
);
  logic [20:0] wa, la;
  logic [8:0]  bank = 9'h000;
  logic [1:0]  step = 2'd0;
  fqc_mode_e   mode = MD_READ;
  logic        wr_on = 1'b0;
  logic        ready = 1'b0;
  logic [15:0] val, last = 16'h0000;
  assign wa = byte_n ? addr : {1'b0, addr[20:1]};
  always @(negedge we_n or negedge ce_n)
    if (!we_n && !ce_n) begin
      la = wa;
      wr_on = 1'b1;
    end
  always @(posedge we_n or posedge ce_n)
    if (wr_on) begin
      wr_on = 1'b0;
      if (dq_in == CMD_RESET) begin
        mode = MD_READ;
        step = 2'd0;
      end else if (step == 2'd0 && la[11:0] == 12'h555 && dq_in == CMD_UNLK1)
        step = 2'd1;
      else if (step == 2'd0 && la[11:0] == 12'h055 && dq_in == CMD_QUERY)
        mode = MD_QUERY;
      else if (step == 2'd1 && la[11:0] == 12'h2AA && dq_in == CMD_UNLK2)
        step = 2'd2;
      else if (step == 2'd2 && la[11:0] == 12'h555 &&
               dq_in == CMD_AUTOSEL) begin
        mode = MD_AUTOSEL;
        bank = la[20:12];
        step = 2'd0;
      end else begin
        mode = MD_READ;
        step = 2'd0;
      end
    end
  always_comb begin
    val = wa[15:0] ^ 16'hA5A5;
    if (mode == MD_QUERY)
      case (wa[7:0])
        8'h40: val = 16'h0050;
        8'h41: val = 16'h0052;
        8'h42: val = 16'h0049;
        8'h43, 8'h44: val = 16'h0031;
        8'h46: val = 16'h0002;
        8'h47, 8'h48: val = 16'h0001;
        8'h49: val = 16'h0004;
        8'h4A: val = {8'h00, UNI};
        8'h4D: val = 16'h0085;
        8'h4E: val = 16'h0095;
        8'h4F: val = TOP ? 16'h0003 : 16'h0002;
        default: val = 16'h0000;
      endcase
    else if (mode == MD_AUTOSEL && wa[20:12] == bank)
      case (wa[7:0])
        8'h00: val = MAKER;
        8'h01: val = DEVICE;
        8'h02: val = {15'h0000, wa[8]};
        default: val = wa[15:0] ^ 16'hA5A5;
      endcase
  end
  // Data only after the full access time; early samples see garbage
  always @(negedge oe_n) begin
    ready = 1'b0;
    #(T_ACCESS_NS);
    ready = !oe_n;
  end
  always @(posedge oe_n) begin
    last = val;
    ready = 1'b0;
  end
  assign dq_out = (ready && !oe_n && !ce_n) ? val : ~last;
endmodule : fqc_flash_mdl
`default_nettype wire

/* File: flash_query_cmd_autoselect_tb_top.sv */
// Testbench: query, autoselect and reset sequences through the controller
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, (g), (e)); end end
module flash_query_cmd_autoselect_tb_top;
  import fqc_pkg::*;
  typedef struct packed {
    logic        bm;
    logic [2:0]  op;
    logic [20:0] a;
    logic [15:0] e;
  } fqc_row_s;
  localparam logic [15:0] MK  = 16'h00C3; // Arbitrary value
  localparam logic [15:0] DEV = 16'h5A3C; // Arbitrary value
  localparam logic [7:0]  UNI = 8'h1E;
  localparam logic [2:0]  Q   = OP_QUERY;
  localparam logic [2:0]  S   = OP_AUTOSEL;
  fqc_row_s rows [23] = '{
    '{0,Q,'h40,'h50}, '{0,Q,'h41,'h52}, '{0,Q,'h42,'h49},
    '{0,Q,'h43,'h31}, '{0,Q,'h44,'h31}, '{0,Q,'h45,'h00},
    '{0,Q,'h46,'h02}, '{0,Q,'h47,'h01}, '{0,Q,'h48,'h01},
    '{0,Q,'h49,'h04}, '{0,Q,'h4A,UNI}, '{0,Q,'h4B,'h00},
    '{0,Q,'h4C,'h00}, '{0,Q,'h4D,'h85}, '{0,Q,'h4E,'h95},
    '{0,Q,'h4F,'h02}, '{1,Q,'h40,'h50}, '{1,Q,'h4F,'h02},
    '{0,S,'h1000,MK}, '{0,S,'h1001,DEV}, '{1,S,'h1001,DEV},
    '{0,S,'h1102,'h01}, '{1,S,'h1002,'h00}};
  logic              mclk, sys_rst, sw_wr, sw_rd, timing_limit_flag;
  logic              flash_ce_n, flash_we_n, flash_oe_n, flash_byte_n;
  logic              flash_dq_oe;
  logic [3:0]        sw_addr;
  logic [31:0]       sw_wdata, sw_rdata, r;
  logic [ADDR_W-1:0] flash_addr;
  logic [DATA_W-1:0] flash_dq_o, flash_dq_i, mdl_dq;
  int                n_errors = 0;
  int                total_checks = 0;
  fqc_ctrl fqc_ctrl_i (.mclk, .sys_rst, .sw_addr, .sw_wdata, .sw_wr, .sw_rd,
    .sw_rdata, .flash_ce_n, .flash_we_n, .flash_oe_n, .flash_byte_n,
    .flash_addr, .flash_dq_o, .flash_dq_oe, .flash_dq_i, .timing_limit_flag);
  fqc_flash_mdl #(.MAKER(MK), .DEVICE(DEV), .UNI(UNI), .TOP(1'b0))
    fqc_flash_mdl_i (.addr(flash_addr), .ce_n(flash_ce_n), .we_n(flash_we_n),
    .oe_n(flash_oe_n), .byte_n(flash_byte_n), .dq_in(flash_dq_i),
    .dq_out(mdl_dq));
  assign flash_dq_i = flash_dq_oe ? flash_dq_o : mdl_dq;
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  task automatic end_sim;
    if (n_errors == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_sim
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge mclk);
    sw_wr <= 1'b0;
    @(posedge mclk);
  endtask : wr
  task automatic rd(input logic [3:0] a);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge mclk);
    sw_rd <= 1'b0;
    @(negedge mclk);
    r = sw_rdata;
    @(posedge mclk);
  endtask : rd
  task automatic fop(input logic [2:0] o, input logic [20:0] a,
                     input logic [15:0] d);
    int i;
    wr(REG_ADDR, {11'h000, a});
    wr(REG_WDATA, {16'h0000, d});
    wr(REG_CMD, {29'h0000_0000, o});
    for (i = 0; i < 300; i++) begin
      rd(REG_STATUS);
      if (r[0] === 1'b0) break;
    end
    if (i == 300) begin
      n_errors++;
      end_sim();
    end
  endtask : fop
  task automatic frd(input logic [20:0] a);
    fop(OP_READ, a, 16'h0000);
    rd(REG_RDATA);
  endtask : frd
  initial begin
    {sys_rst, sw_wr, sw_rd, timing_limit_flag} <= 4'b1000;
    sw_addr <= 4'h0;
    sw_wdata <= 32'h0000_0000;
    repeat (6) @(posedge mclk);
    sys_rst <= 1'b0;
    rd(REG_STATUS);
    `CHK(r[3:2], MD_READ)
    frd(21'h00_0123);
    `CHK(r[15:0], 16'hA486)
    foreach (rows[k]) begin
      wr(REG_CFG, {22'h00_0000, UNI, 1'b0, rows[k].bm});
      fop(rows[k].op, rows[k].a, 16'h0000);
      frd(rows[k].a);
      `CHK(r[15:0], rows[k].e)
      fop(OP_RESET, rows[k].a, 16'h0000);
      frd(rows[k].a);
      `CHK(r[15:0], rows[k].a[15:0] ^ 16'hA5A5)
    end
    // Broken unlock: device must stay in array read
    fop(OP_WRITE, ADR_UNLK1, CMD_UNLK1);
    fop(OP_WRITE, ADR_UNLK2, 16'h0056);
    fop(OP_WRITE, 21'h00_1555, CMD_AUTOSEL);
    frd(21'h00_1000);
    `CHK(r[15:0], 16'hB5A5)
    // Reset after both unlock cycles drops the partial sequence
    fop(OP_WRITE, ADR_UNLK1, CMD_UNLK1);
    fop(OP_WRITE, ADR_UNLK2, CMD_UNLK2);
    fop(OP_RESET, 21'h00_0000, 16'h0000);
    fop(OP_WRITE, 21'h00_1555, CMD_AUTOSEL);
    frd(21'h00_1000);
    `CHK(r[15:0], 16'hB5A5)
    fop(OP_QUERY, 21'h00_0000, 16'h0000);
    fop(OP_AUTOSEL, 21'h00_1000, 16'h0000);
    rd(REG_STATUS);
    `CHK(r[4:2], {1'b0, MD_QUERY})
    frd(21'h00_1000);
    `CHK(r[15:0], 16'h0000)
    wr(REG_CFG, {22'h00_0000, 8'h1F, 2'b00});
    frd(21'h00_004A);
    timing_limit_flag <= 1'b1;
    repeat (2) @(posedge mclk);
    timing_limit_flag <= 1'b0;
    rd(REG_STATUS);
    `CHK(r[5:4], 2'b11)
    wr(REG_STATUS, 32'h0000_0030);
    fop(OP_RESET, 21'h1F_0F0F, 16'h0000);
    rd(REG_STATUS);
    `CHK(r[5:2], 4'h0)
    // Reset while a read is in flight: pins idle, status and data cleared
    wr(REG_CMD, {29'h0000_0000, OP_READ});
    repeat (4) @(posedge mclk);
    sys_rst <= 1'b1;
    repeat (6) @(posedge mclk);
    sys_rst <= 1'b0;
    rd(REG_STATUS);
    `CHK(r[5:0], 6'h00)
    rd(REG_RDATA);
    `CHK(r, 32'h0000_0000)
    frd(21'h00_0123);
    `CHK(r[15:0], 16'hA486)
    rd(4'hF);
    `CHK(r, 32'h0000_0000)
    end_sim();
  end
endmodule : flash_query_cmd_autoselect_tb_top
`default_nettype wire
